// *** logic/smb_serial_interface.sv ***
// SMBus/I2C byte engine, master and slave, with APB registers
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// [RULE_01] Bus free after >10 idle clock-source ticks
// [RULE_02] Pending START issues once bus goes free
// [RULE_03] Free timeout needs clock source, even slave
// [RULE_04] Software resets interface on SCL-low timeout
// [RULE_05] SCL clocked only as master
// [RULE_06] Interrupt on every byte and address
// [RULE_07] Transmitter without hw ack: interrupt after ACK
// [RULE_08] Receiver without hw ack: interrupt before ACK
// [RULE_09] Hardware ack on: interrupt after ACK
// [RULE_10] Interrupt on master START, slave STOP
// [RULE_11] Software reads control register for cause
// [RULE_12] Enable bit enables master and slave events
// [RULE_13] Inhibit: monitor, NACK addresses, no interrupts
// [RULE_14] Inhibit acts after next START only
// [RULE_15] Slave NACK received: expect STOP, vector 0001
// [RULE_16] Slave ACK received: reload data, stay 0100
// [RULE_17] Slave arbitration loss: flag, wait STOP
// [RULE_18] Illegal STOP in slave transmit gives 0101
// [RULE_19] Slave write address acked: next vector 0000
// [RULE_20] Hold SCL low until flag cleared
module smb_serial_interface
  import smb_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Open-drain bus pins
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe
);
  smb_regs_t r, next_r;
  smb_core_t st, n;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  logic [1:0] scl_sy, sda_sy;
  logic scl_d, sda_d;
  logic scl, sda, rise, fall, start_det, stop_det;
  logic tick, wr, wr_ctrl, wr_data, part, drive, addr_hit;

  // Open-drain: only the enables move
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe = st.scl_oe;
  assign sda_oe = st.sda_low;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_sy <= 2'b11;
      sda_sy <= 2'b11;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_sy <= {scl_sy[0], scl_i};
      sda_sy <= {sda_sy[0], sda_i};
      scl_d <= scl_sy[1];
      sda_d <= sda_sy[1];
    end
  end

  assign scl = scl_sy[1];
  assign sda = sda_sy[1];
  assign rise = scl & ~scl_d;
  assign fall = ~scl & scl_d;
  assign start_det = scl & scl_d & sda_d & ~sda;
  assign stop_det = scl & scl_d & ~sda_d & sda;
  assign tick = (st.tcnt == r.div);
  assign wr = psel & penable & pready & pwrite;
  assign wr_ctrl = wr & (paddr == OFS_CTRL);
  assign wr_data = wr & (paddr == OFS_DATA);
  assign part = st.c.master | st.active | st.first;
  assign drive = st.c.tx & ~st.c.arbitration_lost_flag;
  assign addr_hit = ~st.c.master & ~st.inh_l & (st.sh[7:1] == r.addr[7:1]);

  // APB: one wait state so read data leaves a flop
  always_comb begin
    next_r = r;
    next_prdata = '0;
    next_pready = psel & penable & ~pready;
    next_pslverr = 1'b0;
    unique case (paddr)
      OFS_CFG: begin
        next_prdata[7:0] = r.cfg;
        if (wr) next_r.cfg = pwdata[7:0];
      end
      OFS_CTRL: next_prdata[7:0] = st.c;
      OFS_DATA: next_prdata[7:0] = st.sh;
      OFS_ADDR: begin
        next_prdata[7:0] = r.addr;
        if (wr) next_r.addr = pwdata[7:0];
      end
      OFS_DIV: begin
        next_prdata[7:0] = r.div;
        if (wr) next_r.div = pwdata[7:0];
      end
      default: next_pslverr = psel & penable & ~pready;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '{cfg: CFG_RST, addr: ADDR_RST, div: DIV_RST};
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      r <= next_r;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  always_comb begin
    n = st;
    // Bus clock source runs regardless of role
    n.tcnt = tick ? 8'h00 : st.tcnt + 8'h01; // [RULE_03]
    // Software side first so hardware sets below win
    if (wr_data) n.sh = pwdata[7:0]; // [RULE_16]
    if (wr_ctrl) begin
      n.c.sta = pwdata[5];
      n.c.sto = pwdata[4]; // [RULE_18]
      n.c.ack = pwdata[1]; // [RULE_19]
      n.c.arbitration_lost_flag = st.c.arbitration_lost_flag & pwdata[2];
      if (st.c.si && !pwdata[0]) begin
        n.c.si = 1'b0; // [RULE_20]
        if (st.c.master && pwdata[4]) begin
          n.state = ST_STOP;
          n.sda_low = 1'b1;
        end else if (st.c.ack_request_flag) begin
          n.c.ack_request_flag = 1'b0;
          n.sda_low = pwdata[1];
        end else if (drive && (st.c.ack | st.c.master) && st.bcnt == 4'h0) begin
          n.sda_low = ~st.sh[7];
        end
      end
    end
    // Free detection counts source ticks while both lines high
    if (!(scl && sda) || !r.cfg[CFG_FTE]) begin
      n.fcnt = 4'h0;
    end else if (tick) begin
      if (st.fcnt != FREE_TICKS) begin
        n.fcnt = st.fcnt + 4'h1;
      end else begin
        n.busy = 1'b0; // [RULE_01]
        // A slave left mid-frame by a vanished master starts over
        if (!st.c.master && st.state == ST_BITS) n.state = ST_IDLE; // [RULE_02]
      end
    end
    unique case (st.state)
      ST_IDLE: begin
        if (st.c.sta && r.cfg[CFG_EN] && !st.busy) begin
          n.state = ST_START; // [RULE_02]
          n.sda_low = 1'b1;
        end
      end
      ST_START: begin
        if (tick) begin
          n.scl_low = 1'b1;
          n.c.master = 1'b1;
          n.c.tx = 1'b1;
          n.c.sta = 1'b0;
          n.c.si = 1'b1; // [RULE_10]
          n.first = 1'b1;
          n.bcnt = 4'h0;
          n.state = ST_BITS;
        end
      end
      ST_STOP: begin
        if (tick) begin
          if (st.scl_low) n.scl_low = 1'b0;
          else if (scl) n.sda_low = 1'b0;
        end
      end
      ST_BITS: begin
        // Stretching by the far side is honoured: wait for SCL high
        if (st.c.master && !st.c.si && tick) begin
          if (st.scl_low) n.scl_low = 1'b0; // [RULE_05]
          else if (scl) n.scl_low = 1'b1;
        end
        if (rise && part) begin
          n.rose = 1'b1;
          if (st.bcnt != ACK_SLOT) begin
            n.sh = {st.sh[6:0], sda};
            if (drive && (st.c.ack | st.c.master) && st.sh[7] && !sda) begin
              n.c.arbitration_lost_flag = 1'b1; // [RULE_17]
              n.c.master = 1'b0;
              n.sda_low = 1'b0;
            end
          end else if (st.c.tx) begin
            n.c.ack = ~sda;
          end
        end
        // Falls before the first rise belong to the START itself
        if (fall && part && st.rose) begin
          n.rose = 1'b0;
          if (st.bcnt == 4'h7) begin
            n.bcnt = ACK_SLOT;
            if (st.c.tx) begin
              n.sda_low = 1'b0;
              if (st.first) n.rw = st.sh[0];
            end else if (st.first && !addr_hit) begin
              n.first = 1'b0; // [RULE_13]
            end else begin
              if (st.first) begin
                n.active = 1'b1;
                n.rw = st.sh[0];
              end
              if (r.cfg[CFG_HWACK]) begin
                n.sda_low = st.first | st.c.ack;
              end else begin
                n.c.ack_request_flag = 1'b1;
                n.c.si = 1'b1; // [RULE_08]
              end
            end
          end else if (st.bcnt == ACK_SLOT) begin
            n.bcnt = 4'h0;
            n.first = 1'b0;
            n.sda_low = 1'b0;
            if (st.first) begin
              n.c.tx = st.c.master ^ st.rw; // [RULE_19]
              if (!st.c.master) n.c.ack = 1'b1;
            end
            if (r.cfg[CFG_HWACK] || st.c.tx) begin
              n.c.si = 1'b1; // [RULE_06] [RULE_07] [RULE_09]
            end else if (st.first && st.rw) begin
              n.sda_low = ~st.sh[7];
            end
          end else begin
            n.bcnt = st.bcnt + 4'h1;
            // After a NACK the slave lets SDA go
            n.sda_low = drive & (st.c.ack | st.c.master) & ~st.sh[7]; // [RULE_15]
          end
        end
      end
    endcase
    if (start_det) begin
      n.busy = 1'b1;
      n.inh_l = r.cfg[CFG_INH]; // [RULE_14]
      n.bcnt = 4'h0;
      n.rose = 1'b0;
      n.first = 1'b1;
      n.active = 1'b0;
      if (!st.c.master && st.state != ST_START) n.state = ST_BITS;
    end
    if (stop_det) begin
      n.busy = 1'b0;
      n.state = ST_IDLE;
      n.first = 1'b0;
      n.active = 1'b0;
      n.sda_low = 1'b0;
      if (st.active) begin
        n.c.sto = 1'b1; // [RULE_10] [RULE_15] [RULE_17]
        n.c.si = 1'b1;
        n.c.tx = st.c.tx & (st.bcnt != 4'h0); // [RULE_18]
      end
      if (st.c.master) begin
        n.c.master = 1'b0;
        n.c.sto = 1'b0;
        n.c.tx = 1'b0;
      end
    end
    if (!r.cfg[CFG_EN]) begin
      n.state = ST_IDLE; // [RULE_12]
      n.c.master = 1'b0;
      n.active = 1'b0;
      n.first = 1'b0;
      n.busy = 1'b0;
      n.scl_low = 1'b0;
      n.sda_low = 1'b0;
    end
    n.scl_oe = n.scl_low | (n.c.si & (n.state == ST_BITS)); // [RULE_20]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) st <= '0;
    else st <= n;
  end

  property p_free;
    @(posedge pclk) disable iff (!presetn)
    tick && st.fcnt == FREE_TICKS && r.cfg[CFG_FTE] && scl && sda && !start_det |=> !st.busy;
  endproperty
  a_free: assert property (p_free) else $error("bus not freed"); // [RULE_01]

  property p_pend;
    @(posedge pclk) disable iff (!presetn)
    st.state == ST_IDLE && st.c.sta && r.cfg[CFG_EN] && !st.busy && !stop_det
      |=> st.state == ST_START;
  endproperty
  a_pend: assert property (p_pend) else $error("pending start lost"); // [RULE_02]

  property p_tick;
    @(posedge pclk) disable iff (!presetn)
    st.fcnt != 4'h0 && $changed(st.fcnt) |-> $past(tick);
  endproperty
  a_tick: assert property (p_tick) else $error("free count off tick"); // [RULE_03]

  property p_sclm;
    @(posedge pclk) disable iff (!presetn)
    st.scl_oe |-> st.c.master || st.c.si || st.state == ST_STOP;
  endproperty
  a_sclm: assert property (p_sclm) else $error("scl driven as slave"); // [RULE_05]

  property p_before;
    @(posedge pclk) disable iff (!presetn)
    $rose(st.c.si) && st.c.ack_request_flag |-> st.bcnt == ACK_SLOT && !r.cfg[CFG_HWACK];
  endproperty
  a_before: assert property (p_before) else $error("rx irq misplaced"); // [RULE_08]

  property p_after;
    @(posedge pclk) disable iff (!presetn)
    $rose(st.c.si) && st.state == ST_BITS && (r.cfg[CFG_HWACK] || st.c.tx)
      |-> st.bcnt == 4'h0;
  endproperty
  a_after: assert property (p_after) else $error("irq not after ack"); // [RULE_09]

  property p_stop;
    @(posedge pclk) disable iff (!presetn)
    stop_det && st.active && r.cfg[CFG_EN] |=> st.c.si && st.c.sto;
  endproperty
  a_stop: assert property (p_stop) else $error("slave stop missed"); // [RULE_10]

  property p_inh;
    @(posedge pclk) disable iff (!presetn)
    st.inh_l && $rose(st.active) |-> 1'b0;
  endproperty
  a_inh: assert property (p_inh) else $error("inhibited slave addressed"); // [RULE_13]

  property p_inhl;
    @(posedge pclk) disable iff (!presetn)
    $changed(st.inh_l) |-> $past(start_det);
  endproperty
  a_inhl: assert property (p_inhl) else $error("inhibit off start"); // [RULE_14]

  property p_ill;
    @(posedge pclk) disable iff (!presetn)
    stop_det && st.active && st.c.tx && st.bcnt != 4'h0 && r.cfg[CFG_EN]
      |=> st.c.tx && st.c.sto;
  endproperty
  a_ill: assert property (p_ill) else $error("illegal stop not flagged"); // [RULE_18]

  property p_hold;
    @(posedge pclk) disable iff (!presetn)
    st.c.si && st.state == ST_BITS |-> st.scl_oe;
  endproperty
  a_hold: assert property (p_hold) else $error("scl not held"); // [RULE_20]
endmodule
`default_nettype wire

// *** logic/smb_pkg.sv ***
// Shared constants and types for the SMBus serial interface
package smb_pkg;
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_DATA = 8'h08;
  localparam logic [7:0] OFS_ADDR = 8'h0c;
  localparam logic [7:0] OFS_DIV = 8'h10;
  localparam int CFG_EN = 7;
  localparam int CFG_INH = 6;
  localparam int CFG_HWACK = 4;
  localparam int CFG_FTE = 2;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] ADDR_RST = 8'h00;
  localparam logic [7:0] DIV_RST = 8'h13;
  localparam logic [3:0] FREE_TICKS = 4'ha;
  localparam logic [3:0] ACK_SLOT = 4'h8;

  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_BITS, ST_STOP} smb_state_t;

  // Control/status layout, bit 7 down to bit 0
  typedef struct packed {
    logic master;
    logic tx;
    logic sta;
    logic sto;
    logic ack_request_flag;
    logic arbitration_lost_flag;
    logic ack;
    logic si;
  } smb_ctrl_t;

  typedef struct packed {
    smb_state_t state;
    smb_ctrl_t c;
    logic [7:0] sh;
    logic [3:0] bcnt;
    logic [3:0] fcnt;
    logic [7:0] tcnt;
    logic first;
    logic active;
    logic inh_l;
    logic busy;
    logic rw;
    logic rose;
    logic scl_low;
    logic sda_low;
    logic scl_oe;
  } smb_core_t;

  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] addr;
    logic [7:0] div;
  } smb_regs_t;
endpackage

// *** tb/smb_bus_master_model.sv ***
// Behavioural SMBus master on the far side of the pins
`timescale 1ns/1ps
`default_nettype none
module smb_bus_master_model (
  // Wire levels
  input wire logic scl,
  input wire logic sda,
  // Pulls, high = line driven low
  output logic scl_oe,
  output logic sda_oe
);
  // Quarter of the 125 ns link bit
  localparam realtime QT = 31.25;
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
  end
  // High phase waits for scl, so a stretching slave is honoured
  task automatic pulse(output logic seen);
    #QT;
    scl_oe = 1'b0;
    wait (scl === 1'b1);
    #(2*QT);
    seen = sda;
    scl_oe = 1'b1;
    #QT;
  endtask
  task automatic start_cond();
    sda_oe = 1'b1;
    #(2*QT);
    scl_oe = 1'b1;
    #QT;
  endtask
  task automatic send(input logic [7:0] b, output logic ack_n);
    logic dummy;
    for (int i = 7; i >= 0; i--) begin
      sda_oe = ~b[i];
      pulse(dummy);
    end
    sda_oe = 1'b0;
    pulse(ack_n);
  endtask
  // Clock left released after stop: link stands still between frames
  task automatic stop_cond();
    sda_oe = 1'b1;
    #QT;
    scl_oe = 1'b0;
    wait (scl === 1'b1);
    #QT;
    sda_oe = 1'b0;
    #QT;
  endtask
  // Reads one byte, then answers with ack_n on the ninth clock
  task automatic recv(input logic ack_n, output logic [7:0] b);
    logic s;
    sda_oe = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      pulse(s);
      b[i] = s;
    end
    sda_oe = ~ack_n;
    pulse(s);
    sda_oe = 1'b0;
  endtask
  // Lets both lines go with no STOP, so the bus stays busy
  task automatic abandon();
    #QT;
    sda_oe = 1'b0;
    #QT;
    scl_oe = 1'b0;
    #QT;
  endtask
endmodule
`default_nettype wire

// *** tb/smb_serial_interface_bench.sv ***
// Self-checking bench for the SMBus serial interface
`timescale 1ns/1ps
`default_nettype none
module smb_serial_interface_bench;
  import smb_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic scl_oe, sda_oe, m_scl_oe, m_sda_oe, scl, sda, nack;
  int n_errors = 0;
  int comparisons = 0;
  // Pull-ups: low while any party pulls
  assign scl = ~(scl_oe | m_scl_oe);
  assign sda = ~(sda_oe | m_sda_oe);
  smb_serial_interface dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_i(scl), .scl_o(),
    .scl_oe(scl_oe), .sda_i(sda), .sda_o(), .sda_oe(sda_oe));
  smb_bus_master_model far_u (.scl(scl), .sda(sda), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe));
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic test_done();
    if (n_errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Polls status until the flag shows; bounded so a lost event fails
  task automatic wait_irq();
    rd = '0;
    for (int k = 0; k < 200 && rd[0] !== 1'b1; k++) apb(1'b0, OFS_CTRL, 8'h00);
    chk("irq flag", 8'h01, {7'h0, rd[0]});
  endtask
  task automatic t_reset();
    apb(1'b0, OFS_CFG, 8'h00);
    chk("cfg reset", CFG_RST, rd[7:0]);
    apb(1'b0, OFS_DIV, 8'h00);
    chk("div reset", DIV_RST, rd[7:0]);
    apb(1'b0, OFS_CTRL, 8'h00);
    chk("ctrl reset", 8'h00, rd[7:0]);
    apb(1'b1, 8'h14, 8'h5a);
    chk("unmapped error", 8'h01, {7'h0, err});
    apb(1'b1, OFS_DIV, 8'h01);
    apb(1'b1, OFS_ADDR, 8'hb4);
  endtask
  task automatic t_slave_hwack();
    apb(1'b1, OFS_CFG, 8'h90);
    far_u.start_cond();
    far_u.send(8'hb4, nack);
    chk("address ack", 8'h00, {7'h0, nack});
    wait_irq();
    chk("write address status", 8'h03, rd[7:0]);
    apb(1'b1, OFS_CTRL, 8'h02);
    far_u.send(8'ha5, nack);
    wait_irq();
    apb(1'b0, OFS_DATA, 8'h00);
    chk("data byte", 8'ha5, rd[7:0]);
    apb(1'b1, OFS_CTRL, 8'h02);
    far_u.stop_cond();
    wait_irq();
    chk("stop vector", 8'h01, {4'h0, rd[7:4]});
    apb(1'b1, OFS_CTRL, 8'h00);
  endtask
  task automatic t_soft_ack();
    apb(1'b1, OFS_CFG, 8'h80);
    fork
      begin
        far_u.start_cond();
        far_u.send(8'hb4, nack);
      end
      begin
        wait_irq();
        chk("ack request", 8'h01, {7'h0, rd[3]});
        chk("scl held", 8'h00, {7'h0, scl});
        apb(1'b1, OFS_CTRL, 8'h02);
      end
    join
    chk("software ack", 8'h00, {7'h0, nack});
    far_u.stop_cond();
    wait_irq();
    apb(1'b1, OFS_CTRL, 8'h00);
  endtask
  task automatic t_inhibit();
    apb(1'b1, OFS_CFG, 8'hd0);
    far_u.start_cond();
    far_u.send(8'hb4, nack);
    chk("inhibited nack", 8'h01, {7'h0, nack});
    far_u.stop_cond();
    repeat (10) @(posedge pclk);
    apb(1'b0, OFS_CTRL, 8'h00);
    chk("no slave irq", 8'h00, {7'h0, rd[0]});
  endtask
  task automatic t_master();
    apb(1'b1, OFS_CFG, 8'h80);
    apb(1'b1, OFS_CTRL, 8'h20);
    wait_irq();
    chk("start vector", 8'h0c, {4'h0, rd[7:4]});
    chk("master holds scl", 8'h00, {7'h0, scl});
    apb(1'b1, OFS_CTRL, 8'h10);
    repeat (20) @(posedge pclk);
    apb(1'b0, OFS_CTRL, 8'h00);
    chk("role after stop", 8'h00, {4'h0, rd[7:4]});
    apb(1'b1, OFS_CFG, 8'h00);
  endtask
  task automatic t_slave_read();
    logic [7:0] got;
    apb(1'b1, OFS_CFG, 8'h90);
    far_u.start_cond();
    far_u.send(8'hb5, nack);
    wait_irq();
    chk("read address status", 8'h43, rd[7:0]);
    apb(1'b1, OFS_DATA, 8'h3c);
    apb(1'b1, OFS_CTRL, 8'h02);
    far_u.recv(1'b0, got);
    chk("first byte out", 8'h3c, got);
    wait_irq();
    chk("acked byte status", 8'h43, rd[7:0]);
    apb(1'b1, OFS_DATA, 8'hc3);
    apb(1'b1, OFS_CTRL, 8'h02);
    far_u.recv(1'b1, got);
    chk("second byte out", 8'hc3, got);
    wait_irq();
    chk("nacked byte status", 8'h41, rd[7:0]);
    apb(1'b1, OFS_CTRL, 8'h00);
    far_u.stop_cond();
    wait_irq();
    chk("read stop status", 8'h11, rd[7:0]);
    apb(1'b1, OFS_CTRL, 8'h00);
  endtask
  // Bus left busy with no STOP: only the free timeout lets the start out
  task automatic t_free();
    apb(1'b1, OFS_CFG, 8'h84);
    far_u.start_cond();
    far_u.abandon();
    apb(1'b1, OFS_CTRL, 8'h20);
    apb(1'b0, OFS_CTRL, 8'h00);
    chk("start held while busy", 8'h00, {7'h0, rd[7]});
    wait_irq();
    chk("start after free", 8'h0c, {4'h0, rd[7:4]});
    apb(1'b1, OFS_CTRL, 8'h10);
    repeat (20) @(posedge pclk);
    apb(1'b1, OFS_CFG, 8'h00);
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_slave_hwack();
    t_soft_ack();
    t_slave_read();
    t_inhibit();
    t_free();
    t_master();
    test_done();
  end
  // Whole run needs well under 200 us
  initial begin
    #200000;
    n_errors++;
    test_done();
  end
endmodule
`default_nettype wire
